// file: rtl/omc_params.svh
`ifndef OMC_PARAMS_SVH
`define OMC_PARAMS_SVH

// register byte offsets on the wishbone slave
`define OMC_OFF_CTRL     8'h00
`define OMC_OFF_STAT     8'h04

// control register field positions
`define OMC_B_STOP_ALLOW 0
`define OMC_B_DBG_ALLOW  1
`define OMC_B_REF_KEEP   2
`define OMC_B_LOWV_ON    3
`define OMC_B_LOWV_STOP  4
`define OMC_B_RATE_LO    5
`define OMC_B_RATE_HI    7
`define OMC_B_SEL_32K    8
`define OMC_B_PERIPH_W   9
`define OMC_B_CMP_CFG    10
`define OMC_B_KEY_EN     11
`define OMC_B_LVDW_EN    12
`define OMC_B_CMPW_EN    13
`define OMC_CTRL_W       14

// reset values
`define OMC_CTRL_RST     14'h0000
`define OMC_RATE_OFF     3'h0

// restart fetch location and the jump that must sit there
`define OMC_BOOT_PC      16'h3ffd
`define OMC_JMP_OPC      8'hbc
`define OMC_JMP_OPND     16'h3ffe

// cycles after reset release before the synchronised mode pin is valid
`define OMC_BOOT_WAIT    2'h2

`endif

// file: rtl/omc_pkg.sv
package omc_pkg;

	typedef enum logic [2:0] {
		omc_boot   = 3'b000,
		omc_run    = 3'b001,
		omc_halted = 3'b010,
		omc_wait   = 3'b011,
		omc_stop   = 3'b100
	} omc_mode_t;

	typedef enum logic [2:0] {
		cmd_mem        = 3'b000,
		cmd_mem_status = 3'b001,
		cmd_background = 3'b010,
		cmd_regs       = 3'b011,
		cmd_trace      = 3'b100,
		cmd_go         = 3'b101
	} omc_cmd_t;

endpackage : omc_pkg

// file: rtl/omc_top.sv
// Design decisions made here: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`include "omc_params.svh"

module omc_top
	import omc_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        debug_mode_select_pin,
	input  wire logic        reset_pin_n,
	input  wire logic        keypad_wake_pin,
	input  wire logic        lowv_wake_in,
	input  wire logic        cmp_wake_in,
	input  wire logic        periodic_wake_in,
	input  wire logic        wait_exec,
	input  wire logic        stop_exec,
	input  wire logic        halt_exec,
	input  wire logic        brk_hit,
	input  wire logic        cpu_irq,
	input  wire logic        dbg_cmd_valid,
	input  wire logic [2:0]  dbg_cmd_code,
	input  wire logic        dbg_force_reset,
	output logic      [2:0]  mode_o,
	output logic             cpu_clk_on,
	output logic             periph_clk_on,
	output logic             clk_src_on,
	output logic             regulator_full,
	output logic             dbg_clk_on,
	output logic             periodic_src_on,
	output logic             cmp_on,
	output logic             pins_held,
	output logic             pc_advance,
	output logic             boot_fetch,
	output logic      [15:0] boot_addr,
	output logic             sys_reset_req,
	output logic             ilop_reset,
	output logic             dbg_cmd_ack,
	output logic             dbg_cmd_err,
	output logic             dbg_cmd_rej,
	output logic             dbg_mem_go,
	output logic             dbg_trace
);

	localparam int NSYNC = 5;

	omc_mode_t                mode_r, mode_nxt;
	logic [`OMC_CTRL_W-1:0]   ctrl_r;
	logic [1:0]               boot_cnt_r;
	logic                     ack_r;
	logic [31:0]              dat_r;
	logic                     stop_dbg_r, stop_lowv_r, stop_ref_r;
	logic                     pc_adv_r, boot_r, sysrst_r, ilop_r;
	logic                     ack_c_r, err_c_r, rej_c_r, mem_r, trace_r;
	logic                     pc_adv_nxt, boot_nxt, sysrst_nxt, ilop_nxt;
	logic                     ack_c_nxt, err_c_nxt, rej_c_nxt, mem_nxt, trace_nxt;
	logic [NSYNC-1:0]         async_in, sync1_r, sync2_r;

	// every pin or foreign-domain level passes two flops before use
	assign async_in = {periodic_wake_in, cmp_wake_in, lowv_wake_in, keypad_wake_pin, debug_mode_select_pin};
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge ref_clk or negedge resetn) begin
				if (!resetn) begin
					sync1_r[gi] <= 1'b1;
					sync2_r[gi] <= 1'b1;
				end else begin
					sync1_r[gi] <= async_in[gi];
					sync2_r[gi] <= sync1_r[gi];
				end
			end
		end
	endgenerate

	// reset pin gets its own chain: released high means no request
	logic rpin1_r, rpin2_r;
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rpin1_r <= 1'b1;
			rpin2_r <= 1'b1;
		end else begin
			rpin1_r <= reset_pin_n;
			rpin2_r <= rpin1_r;
		end
	end

	// named views of synchronised levels and control fields
	wire       ms_s      = sync2_r[0];
	wire       key_s     = sync2_r[1];
	wire       lowv_s    = sync2_r[2];
	wire       cmp_s     = sync2_r[3];
	wire       per_s     = sync2_r[4];
	wire       pin_rst   = !rpin2_r;
	wire       stop_ok   = ctrl_r[`OMC_B_STOP_ALLOW];
	wire       dbg_allow = ctrl_r[`OMC_B_DBG_ALLOW];
	wire       ref_keep  = ctrl_r[`OMC_B_REF_KEEP];
	wire       lowv_both = ctrl_r[`OMC_B_LOWV_ON] & ctrl_r[`OMC_B_LOWV_STOP];
	wire [2:0] rate      = ctrl_r[`OMC_B_RATE_HI:`OMC_B_RATE_LO];
	wire       sel_32k   = ctrl_r[`OMC_B_SEL_32K];
	wire       rate_on   = (rate != `OMC_RATE_OFF);

	// command classification
	omc_cmd_t cmd;
	assign cmd = omc_cmd_t'(dbg_cmd_code);
	wire cmd_nonintr = (cmd == cmd_mem) || (cmd == cmd_mem_status) || (cmd == cmd_background);
	wire cmd_active  = (cmd == cmd_regs) || (cmd == cmd_trace) || (cmd == cmd_go);
	wire cmd_known   = cmd_nonintr || cmd_active;
	wire bg_cmd      = dbg_cmd_valid && (cmd == cmd_background);

	// the 32 khz reference survives stop when debug was allowed, or when ref_keep is set and the detector keeps the regulator up
	wire src_in_stop = stop_dbg_r | (stop_ref_r & stop_lowv_r);
	wire per_src_ok  = rate_on && (!sel_32k || (mode_r == omc_stop ? src_in_stop : 1'b1));
	wire async_wake  = (key_s & ctrl_r[`OMC_B_KEY_EN]) | (lowv_s & ctrl_r[`OMC_B_LVDW_EN])
	                 | (cmp_s & ctrl_r[`OMC_B_CMPW_EN]);
	wire stop_wake   = async_wake | (per_s & per_src_ok);
	wire wait_wake   = cpu_irq | stop_wake;
	// debug logic only hears the host in stop if it was kept clocked
	wire dbg_live    = (mode_r != omc_stop) || stop_dbg_r;

	// mode sequencing and one-cycle event pulses
	always_comb begin
		mode_nxt   = mode_r;
		pc_adv_nxt = 1'b0;
		boot_nxt   = 1'b0;
		sysrst_nxt = 1'b0;
		ilop_nxt   = 1'b0;
		ack_c_nxt  = 1'b0;
		err_c_nxt  = 1'b0;
		rej_c_nxt  = 1'b0;
		mem_nxt    = 1'b0;
		trace_nxt  = 1'b0;
		// command answer follows the mode in which it arrived
		if (dbg_cmd_valid) begin
			case (mode_r)
				omc_run: begin
					ack_c_nxt = cmd_nonintr;
					mem_nxt   = cmd_nonintr && (cmd != cmd_background);
					rej_c_nxt = !cmd_nonintr;
				end
				omc_halted: begin
					ack_c_nxt = cmd_known;
					mem_nxt   = (cmd == cmd_mem) || (cmd == cmd_mem_status);
					trace_nxt = (cmd == cmd_trace);
					rej_c_nxt = !cmd_known;
				end
				omc_wait, omc_stop: begin
					// low-power modes answer status without touching memory while debug is live, else they reject
					ack_c_nxt = dbg_live && (cmd == cmd_background);
					err_c_nxt = dbg_live && (cmd == cmd_mem_status);
					rej_c_nxt = !(ack_c_nxt || err_c_nxt);
				end
				default: rej_c_nxt = 1'b1;
			endcase
		end
		// resets override every mode change the cpu or host asked for; command answers still go out
		if (pin_rst) begin
			mode_nxt   = omc_run;
			boot_nxt   = 1'b1;
			sysrst_nxt = 1'b1;
		end else if (dbg_force_reset) begin
			mode_nxt   = omc_halted;
			sysrst_nxt = 1'b1;
		end else begin
			case (mode_r)
				omc_boot: begin
					if (boot_cnt_r == `OMC_BOOT_WAIT) begin
						// single look at the pin; pullup default means run
						mode_nxt = ms_s ? omc_run : omc_halted;
						boot_nxt = ms_s;
					end
				end
				omc_run: begin
					if (stop_exec && stop_ok) begin
						mode_nxt = omc_stop;
					end else if (stop_exec) begin
						mode_nxt   = omc_boot;
						ilop_nxt   = 1'b1;
						sysrst_nxt = 1'b1;
					end else if (wait_exec) begin
						mode_nxt = omc_wait;
					end else if (halt_exec || brk_hit || bg_cmd) begin
						mode_nxt = omc_halted;
					end
				end
				omc_halted: begin
					if (dbg_cmd_valid && (cmd == cmd_go)) begin
						mode_nxt = omc_run;
					end
				end
				omc_wait: begin
					if (bg_cmd) begin
						mode_nxt = omc_halted;
					end else if (wait_wake) begin
						mode_nxt   = omc_run;
						pc_adv_nxt = 1'b1;
					end
				end
				omc_stop: begin
					if (bg_cmd && stop_dbg_r) begin
						mode_nxt = omc_halted;
					end else if (stop_wake) begin
						mode_nxt   = omc_run;
						pc_adv_nxt = 1'b1;
					end
				end
				default: mode_nxt = omc_boot;
			endcase
		end
	end

	// mode state and the settings captured at stop entry
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			mode_r     <= omc_boot;
			boot_cnt_r <= 2'h0;
			stop_dbg_r <= 1'b0;
			stop_lowv_r <= 1'b0;
			stop_ref_r <= 1'b0;
		end else begin
			mode_r     <= mode_nxt;
			boot_cnt_r <= (mode_nxt == omc_boot && mode_r == omc_boot) ? boot_cnt_r + 2'h1 : 2'h0;
			if (mode_r != omc_stop && mode_nxt == omc_stop) begin
				stop_dbg_r <= dbg_allow;
				stop_lowv_r <= lowv_both;
				stop_ref_r <= ref_keep;
			end
		end
	end

	// registered pulses toward cpu and host
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			{pc_adv_r, boot_r, sysrst_r, ilop_r} <= 4'h0;
			{ack_c_r, err_c_r, rej_c_r, mem_r, trace_r} <= 5'h00;
		end else begin
			{pc_adv_r, boot_r, sysrst_r, ilop_r} <= {pc_adv_nxt, boot_nxt, sysrst_nxt, ilop_nxt};
			{ack_c_r, err_c_r, rej_c_r, mem_r, trace_r} <= {ack_c_nxt, err_c_nxt, rej_c_nxt, mem_nxt, trace_nxt};
		end
	end

	// clock and power steering decoded straight from mode state, the settings captured at stop entry and control bits
	assign mode_o          = mode_r;
	assign cpu_clk_on      = (mode_r == omc_run);
	assign periph_clk_on   = (mode_r == omc_run) || (mode_r == omc_halted)
	                       || ((mode_r == omc_wait) && ctrl_r[`OMC_B_PERIPH_W]);
	assign clk_src_on      = (mode_r == omc_stop) ? src_in_stop : 1'b1;
	assign regulator_full  = (mode_r == omc_stop) ? (stop_dbg_r | stop_lowv_r) : 1'b1;
	assign dbg_clk_on      = dbg_live;
	assign periodic_src_on = per_src_ok;
	assign cmp_on          = ((mode_r == omc_wait) || (mode_r == omc_stop)) ? ctrl_r[`OMC_B_CMP_CFG] : 1'b1;
	assign pins_held       = (mode_r == omc_wait) || (mode_r == omc_stop);
	assign pc_advance      = pc_adv_r;
	assign boot_fetch      = boot_r;
	assign boot_addr       = `OMC_BOOT_PC;
	assign sys_reset_req   = sysrst_r;
	assign ilop_reset      = ilop_r;
	assign dbg_cmd_ack     = ack_c_r;
	assign dbg_cmd_err     = err_c_r;
	assign dbg_cmd_rej     = rej_c_r;
	assign dbg_mem_go      = mem_r;
	assign dbg_trace       = trace_r;

	// wishbone decode; unmapped reads return zero and still ack
	wire        wb_req   = wb_cyc_i && wb_stb_i && !ack_r;
	wire        hit_ctrl = (wb_adr_i == `OMC_OFF_CTRL);
	wire        hit_stat = (wb_adr_i == `OMC_OFF_STAT);
	wire [31:0] stat_val = {22'h000000, regulator_full, clk_src_on, stop_lowv_r, stop_dbg_r, ms_s, cpu_clk_on,
	                        1'b0, mode_r};
	wire [31:0] rd_mux   = hit_ctrl ? {18'h00000, ctrl_r} : (hit_stat ? stat_val : 32'h00000000);
	wire        wr_ctrl  = wb_req && wb_we_i && hit_ctrl;

	// one wait state: ack follows the request edge and drops after one cycle
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ack_r  <= 1'b0;
			dat_r  <= 32'h00000000;
			ctrl_r <= `OMC_CTRL_RST;
		end else begin
			ack_r <= wb_req;
			if (wb_req && !wb_we_i) begin
				dat_r <= rd_mux;
			end
			if (wr_ctrl && wb_sel_i[0]) begin
				ctrl_r[7:0] <= wb_dat_i[7:0];
			end
			if (wr_ctrl && wb_sel_i[1]) begin
				ctrl_r[`OMC_CTRL_W-1:8] <= wb_dat_i[`OMC_CTRL_W-1:8];
			end
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;

	// checks on the sequencer
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	wire calm = !pin_rst && !dbg_force_reset;

	a_boot_run_fetch: assert property ((mode_r == omc_boot) && (mode_nxt == omc_run) && calm
		|=> boot_fetch && (boot_addr == 16'h3ffd) && cpu_clk_on)
		else $error("run entry without restart fetch");

	a_halt_to_susp: assert property ((mode_r == omc_run) && calm && !stop_exec && !wait_exec
		&& (halt_exec || brk_hit) |=> (mode_r == omc_halted))
		else $error("halt or breakpoint did not enter background");

	a_susp_no_cpu: assert property ((mode_r == omc_halted) |-> !cpu_clk_on && !pc_advance)
		else $error("cpu clocked in background mode");

	a_active_cmd_gate: assert property (dbg_cmd_valid && cmd_active && (mode_r != omc_halted)
		|=> dbg_cmd_rej && !dbg_cmd_ack && !dbg_trace)
		else $error("active command taken outside background");

	a_wait_irq_resume: assert property ((mode_r == omc_wait) && calm && !bg_cmd && cpu_irq
		|=> pc_advance && (mode_r == omc_run) ##1 !pc_advance)
		else $error("wait exit not a single pc advance");

	a_wait_status_err: assert property ((mode_r == omc_wait) && dbg_cmd_valid && (cmd == cmd_mem_status)
		|=> dbg_cmd_err && !dbg_mem_go)
		else $error("status command in wait touched memory");

	a_stop_illegal: assert property ((mode_r == omc_run) && calm && stop_exec && !stop_ok
		|=> ilop_reset && sys_reset_req && (mode_r == omc_boot))
		else $error("stop without allow bit not forced to reset");

	a_stop_regulator: assert property ((mode_r == omc_stop)
		|-> (regulator_full == (stop_dbg_r || stop_lowv_r)) && !cpu_clk_on && !periph_clk_on)
		else $error("stop regulator or clocks wrong");

	a_rate_off: assert property ((rate == 3'h0) |-> !periodic_src_on)
		else $error("periodic source on with rate zero");

endmodule : omc_top

// file: sim/omc_dbg_host.sv
`timescale 1ns/1ps

// command-level model of the external debug host on the mode/debug pin
module omc_dbg_host (
	input  wire logic       ref_clk,
	output logic            dbg_cmd_valid,
	output logic      [2:0] dbg_cmd_code,
	output logic            dbg_force_reset,
	output logic            debug_mode_select_pin
);
	// idle pin rests at the pullup level; code is scrambled outside frames
	initial begin
		dbg_cmd_valid = 1'b0;
		dbg_cmd_code = 3'h5;
		dbg_force_reset = 1'b0;
		debug_mode_select_pin = 1'b1;
	end

	// host may pull the pin low across reset to force background
	task hold_ms(input logic lvl);
		debug_mode_select_pin <= lvl;
	endtask : hold_ms

	// one frame after an optional idle gap, so slow hosts are covered too
	task send(input logic [2:0] c, input int gap);
		repeat (gap) @(posedge ref_clk);
		@(posedge ref_clk);
		dbg_cmd_valid <= 1'b1;
		dbg_cmd_code <= c;
		@(posedge ref_clk);
		dbg_cmd_valid <= 1'b0;
		dbg_cmd_code <= ~c;
	endtask : send

	// force-reset command, a single strobe
	task force_rst;
		@(posedge ref_clk);
		dbg_force_reset <= 1'b1;
		@(posedge ref_clk);
		dbg_force_reset <= 1'b0;
	endtask : force_rst
endmodule : omc_dbg_host

// file: sim/tb.sv
`timescale 1ns/1ps
`include "omc_params.svh"

module tb;
	import omc_pkg::*;
	logic        ref_clk, resetn, cyc, stb, we, rpin_n, irq, ack, pwk, vld, frc, ms;
	logic        pc_adv, bfetch, srr, ilop, bfs;
	logic [7:0]  adr;
	wire  [7:0]  lvl;
	logic [3:0]  sel, ev;
	logic [31:0] wdat, rdat, rd, r;
	logic [2:0]  wk, mode, code;
	wire  [4:0]  rsp;
	logic [15:0] baddr;
	int          failures, cmp_count, em, dbg, t, seed;
	logic [13:0] sc [3] = '{14'h0001, 14'h0003, 14'h001d};
	logic [7:0]  sl [3] = '{8'h01, 8'h39, 8'h31};

	omc_top i_omc_top (.ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.debug_mode_select_pin(ms), .reset_pin_n(rpin_n), .keypad_wake_pin(wk[0]), .lowv_wake_in(wk[1]),
		.cmp_wake_in(wk[2]), .periodic_wake_in(pwk), .wait_exec(ev[0]), .stop_exec(ev[1]),
		.halt_exec(ev[2]), .brk_hit(ev[3]), .cpu_irq(irq), .dbg_cmd_valid(vld), .dbg_cmd_code(code),
		.dbg_force_reset(frc), .mode_o(mode), .cpu_clk_on(lvl[7]), .periph_clk_on(lvl[6]),
		.clk_src_on(lvl[5]), .regulator_full(lvl[4]), .dbg_clk_on(lvl[3]), .periodic_src_on(lvl[2]),
		.cmp_on(lvl[1]), .pins_held(lvl[0]), .pc_advance(pc_adv), .boot_fetch(bfetch),
		.boot_addr(baddr), .sys_reset_req(srr), .ilop_reset(ilop), .dbg_cmd_ack(rsp[4]),
		.dbg_cmd_err(rsp[3]), .dbg_cmd_rej(rsp[2]), .dbg_mem_go(rsp[1]), .dbg_trace(rsp[0]));

	omc_dbg_host i_omc_dbg_host (.ref_clk(ref_clk), .dbg_cmd_valid(vld), .dbg_cmd_code(code),
		.dbg_force_reset(frc), .debug_mode_select_pin(ms));

	// free-running bus clock, 4 ns
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// boot fetch is a single pulse; latch it so a late look still sees it
	always @(posedge ref_clk) begin
		if (bfetch === 1'b1)
			bfs <= 1'b1;
	end

	task chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk

	task results;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : results

	task td;
		t++;
		$display("test %0d done", t);
	endtask : td

	// model of command answers: ack 10, err 08, rej 04, mem 02, trace 01
	function automatic logic [4:0] ex(input int c);
		if (em == 4 && dbg == 0)
			return 5'h04;
		if (em > 2)
			return c == 1 ? 5'h08 : (c == 2 ? 5'h10 : 5'h04);
		if (c < 2)
			return 5'h12;
		if (c == 2)
			return 5'h10;
		if (c < 6 && em == 2)
			return c == 4 ? 5'h11 : 5'h10;
		return 5'h04;
	endfunction : ex

	task cmd(input int c);
		logic [4:0] e;
		e = ex(c);
		i_omc_dbg_host.send(c[2:0], {$random(seed)} % 3);
		#1;
		chk(rsp, e);
		if (e[4] && c == 2)
			em = 2;
		else if (e[4] && c == 5)
			em = 1;
		chk(mode, em);
	endtask : cmd

	// bounded wait for a mode; the model then takes that mode
	task wm(input int m);
		int k;
		k = 0;
		while (mode !== m[2:0] && k < 30) begin
			@(posedge ref_clk);
			#1;
			k++;
		end
		em = m;
		chk(mode, em);
	endtask : wm

	// classic wishbone cycle, held until ack is sampled high; only the watchdog ends a hang
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'h3;
		do begin
			@(posedge ref_clk);
		end while (ack !== 1'b1);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		// ack is a single-cycle pulse; it must be gone one edge after release
		@(posedge ref_clk);
		chk(ack, 0);
	endtask : wb

	task evp(input int i);
		@(posedge ref_clk);
		ev[i] <= 1'b1;
		@(posedge ref_clk);
		ev[i] <= 1'b0;
		#1;
	endtask : evp

	task rst(input logic p, input int m);
		@(posedge ref_clk);
		i_omc_dbg_host.hold_ms(p);
		resetn <= 1'b0;
		repeat (6) @(posedge ref_clk);
		bfs = 1'b0;
		resetn <= 1'b1;
		wm(m);
		i_omc_dbg_host.hold_ms(~p);
		repeat (4) @(posedge ref_clk);
		#1;
		chk(mode, em);
		if (m == 1)
			chk(bfs, 1);
		i_omc_dbg_host.hold_ms(1'b1);
	endtask : rst

	// watchdog well past the few hundred cycles the run needs
	initial begin
		#100000;
		failures++;
		results;
	end

	initial begin
		seed = 32'h0d71bb67;
		{resetn, cyc, stb, we, irq, pwk, bfs} = '0;
		{adr, sel, ev, wdat, wk} = '0;
		rpin_n = 1'b1;
		dbg = 0;
		rst(1'b0, 2);
		td;
		rst(1'b1, 1);
		chk(baddr, `OMC_BOOT_PC);
		for (int c = 0; c < 8; c++)
			if (c != 2)
				cmd(c);
		cmd(2);
		for (int c = 0; c < 6; c++)
			cmd(c);
		td;
		evp(2);
		em = 2;
		chk(mode, em);
		cmd(5);
		evp(3);
		em = 2;
		chk(mode, em);
		cmd(5);
		i_omc_dbg_host.force_rst;
		#1;
		chk(srr, 1);
		em = 2;
		chk(mode, em);
		cmd(5);
		td;
		evp(0);
		em = 3;
		chk(mode, em);
		chk(lvl & 8'hf7, 8'h31);
		cmd(1);
		cmd(0);
		cmd(4);
		cmd(2);
		cmd(5);
		evp(0);
		@(posedge ref_clk);
		irq <= 1'b1;
		@(posedge ref_clk);
		irq <= 1'b0;
		#1;
		chk(mode, 1);
		chk(pc_adv, 1);
		td;
		evp(1);
		chk(ilop, 1);
		chk(mode, 0);
		wm(1);
		td;
		for (int i = 0; i < 3; i++) begin
			wb(1'b1, `OMC_OFF_CTRL, 32'(sc[i]) | (32'h800 << i));
			dbg = sc[i][1];
			evp(1);
			wm(4);
			chk(lvl, sl[i]);
			cmd(1);
			cmd(0);
			@(posedge ref_clk);
			wk[i] <= 1'b1;
			wm(1);
			chk(pc_adv, 1);
			@(posedge ref_clk);
			wk[i] <= 1'b0;
		end
		td;
		wb(1'b1, `OMC_OFF_CTRL, 32'h0001);
		evp(1);
		wm(4);
		@(posedge ref_clk);
		pwk <= 1'b1;
		repeat (8) @(posedge ref_clk);
		#1;
		chk(mode, 4);
		bfs = 1'b0;
		@(posedge ref_clk);
		pwk <= 1'b0;
		rpin_n <= 1'b0;
		wm(1);
		@(posedge ref_clk);
		rpin_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		chk(bfs, 1);
		wb(1'b1, `OMC_OFF_CTRL, 32'h0021);
		evp(1);
		wm(4);
		@(posedge ref_clk);
		pwk <= 1'b1;
		wm(1);
		chk(pc_adv, 1);
		@(posedge ref_clk);
		pwk <= 1'b0;
		// 32 khz source without the detector bits dies in stop, so no periodic wake
		wb(1'b1, `OMC_OFF_CTRL, 32'h0121);
		evp(1);
		wm(4);
		@(posedge ref_clk);
		pwk <= 1'b1;
		repeat (8) @(posedge ref_clk);
		#1;
		chk(mode, 4);
		chk(lvl[2], 0);
		@(posedge ref_clk);
		pwk <= 1'b0;
		rpin_n <= 1'b0;
		wm(1);
		@(posedge ref_clk);
		rpin_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		td;
		wb(1'b1, `OMC_OFF_CTRL, 32'h0803);
		dbg = 1;
		evp(1);
		wm(4);
		cmd(2);
		cmd(3);
		cmd(5);
		td;
		r = $random(seed);
		wb(1'b1, `OMC_OFF_CTRL, r);
		wb(1'b0, `OMC_OFF_CTRL, 32'h0);
		chk(rd, r & 32'h3fff);
		wb(1'b1, `OMC_OFF_STAT, r);
		wb(1'b0, `OMC_OFF_STAT, 32'h0);
		chk(rd[4:0], 5'h10 | em);
		wb(1'b1, 8'h10, r);
		wb(1'b0, 8'h10, 32'h0);
		chk(rd, 0);
		td;
		results;
	end
endmodule : tb
